// File: verilog/io_bank_pkg.sv
package io_bank_pkg;

   // ----------------------------------------------------------------------
   // Variants, switch positions and register selectors
   // ----------------------------------------------------------------------
   typedef enum logic [0:0] {VAR_FOUR_AO = 1'b0, VAR_EIGHT_AI = 1'b1} variant_type;
   typedef enum logic [1:0] {SW_OFF = 2'b00, SW_AUTO = 2'b01, SW_HAND = 2'b11} switch_type;
   typedef enum logic [2:0] {
      REG_NONE  = 3'b000,
      REG_TRIM  = 3'b001,
      REG_RATE  = 3'b011,
      REG_OUT   = 3'b010,
      REG_IN    = 3'b110,
      REG_RANGE = 3'b111
   } reg_sel_type;

   // ----------------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------------
   localparam logic [15:0] ADDR_TRIM       = 16'h000D;
   localparam logic [15:0] ADDR_RATE       = 16'h000F;
   localparam logic [15:0] ADDR_OUT_BASE   = 16'h0064;
   localparam logic [15:0] ADDR_IN_4AO     = 16'h00BE;
   localparam logic [15:0] ADDR_IN_8AI     = 16'h006C;
   localparam logic [15:0] ADDR_RANGE_BASE = 16'h00C8;

   // ----------------------------------------------------------------------
   // Channel counts
   // ----------------------------------------------------------------------
   localparam int NUM_IN_MAX  = 10;
   localparam int NUM_IN_4AO  = 10;
   localparam int NUM_IN_8AI  = 8;
   localparam int NUM_OUT_MAX = 12;
   localparam int NUM_OUT_4AO = 12;
   localparam int NUM_OUT_8AI = 8;
   localparam int NUM_AO_MAX  = 8;
   localparam int NUM_AO_4AO  = 4;
   localparam int NUM_AO_8AI  = 8;
   localparam int NUM_RELAY   = 8;

   // ----------------------------------------------------------------------
   // Values, thresholds and reset values
   // ----------------------------------------------------------------------
   localparam logic [11:0] IN_FULL_BASE   = 12'h400;
   localparam logic [11:0] IN_FULL_4AO    = 12'hFFF;
   localparam logic [11:0] IN_LED_BASE    = 12'h200;
   localparam logic [11:0] IN_LED_4AO     = 12'h7FF;
   localparam logic [15:0] OUT_ON_THRESH  = 16'h0200;
   localparam logic [15:0] AO_LEVEL_FULL  = 16'h0400;
   localparam int          AO_W           = 10;
   localparam logic [9:0]  AO_FULL        = 10'h3E8;
   localparam logic [17:0] AO_SCALE_MUL   = 18'h0007D;
   localparam logic [12:0] AO_OFFSET_ZERO = 13'h0080;
   localparam logic [7:0]  TRIM_RESET     = 8'h80;
   localparam logic [15:0] TRIM_MAX       = 16'h00FF;
   localparam logic [7:0]  RATE_RESET     = 8'h01;
   localparam logic [15:0] RATE_MAX       = 16'h0001;
   localparam logic [7:0]  RANGE_RESET    = 8'h00;
   localparam logic [7:0]  RANGE_PULSE    = 8'h06;
   localparam logic [15:0] RANGE_MAX      = 16'h000D;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          PULSE_FILTER_NS = 100_000;
   localparam int          PULSE_FILTER_CYC = (PULSE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FILTER_W        = 10;
   localparam logic [9:0]  FILTER_LAST     = 10'(PULSE_FILTER_CYC - 1);

endpackage : io_bank_pkg

// File: verilog/pulse_filter.sv
`timescale 1ns/1ns
module pulse_filter
   import io_bank_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // Raw pin and counting mode.
   input  wire logic pin_i,
   input  wire logic enable_i,
   // Filtered rising edge.
   output logic      rise_o
);

   logic                sync_a;
   logic                sync_b;
   logic                level;
   logic [FILTER_W-1:0] stable_cnt;

   // Two flip-flops bring the pin into the clock domain.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= pin_i;
         sync_b <= sync_a;
      end
   end

   // Counts how long the pin has differed from the filtered level.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stable_cnt <= '0;
      end else if (sync_b == level || stable_cnt == FILTER_LAST) begin
         stable_cnt <= '0;
      end else begin
         stable_cnt <= stable_cnt + 10'h001;
      end
   end

   // The level follows only a change that outlives the filter, far below a 1 kHz half period.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         level  <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         if (sync_b != level && stable_cnt == FILTER_LAST) begin
            level <= sync_b;
         end
         rise_o <= enable_i && !level && sync_b && stable_cnt == FILTER_LAST;
      end
   end

   // Assertions.
   a_rise_filtered: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rise_o |-> level && $past(enable_i) && !$past(level))
      else $error("Pulse edge reported without a filtered rise.");

endmodule : pulse_filter

// File: verilog/io_register_bank.sv
// Functional notes
// - Base variant inputs: 10-bit, full scale 1024.
// - Base input LED lit above 512.
// - Four-output variant: full 4095, LED above 2047.
// - Input values at 190-199 or 108-115.
// - Hand position forces the output fully on.
// - Off position forces the output inactive.
// - Auto drives analog output from its register.
// - Relay or sink active above 512 in auto.
// - Analog register 0..1024 maps 0..10 V.
// - Output registers clear at power-up.
// - Output LED lit when register exceeds 512.
// - Output registers at 100-111 or 100-107.
// - Trim at 13 offsets analog, 128 neutral.
// - Trim saved nonvolatile, reloaded at power-up.
// - Register 15 selects 19200 or 9600 bps.
// - All registers reached as a serial slave.
// - Range bytes per input at 200-209.
// - Range codes 0..13, code 6 is pulse.
// - Pulse inputs handle rates below 1 kHz.
`timescale 1ns/1ns
module io_register_bank
   import io_bank_pkg::*;
#(
   parameter variant_type VARIANT = VAR_FOUR_AO
) (
   // Clock and reset.
   input  wire logic                                 clk_i,
   input  wire logic                                 sys_rst_i,
   // Decoded register transactions from the serial frame layer.
   input  wire logic                                 req_i,
   input  wire logic                                 wr_i,
   input  wire logic [15:0]                          addr_i,
   input  wire logic [15:0]                          wdata_i,
   output logic                                      ack_o,
   output logic                                      exc_o,
   output logic [15:0]                               rdata_o,
   // Line rate handling.
   input  wire logic                                 resp_done_i,
   output logic                                      baud_sel_o,
   // Nonvolatile trim store.
   input  wire logic                                 nv_valid_i,
   input  wire logic [7:0]                           nv_trim_i,
   output logic                                      nv_wr_o,
   output logic [7:0]                                nv_data_o,
   // Converter results and field pins.
   input  wire logic                                 adc_valid_i,
   input  wire logic [3:0]                           adc_chan_i,
   input  wire logic [11:0]                          adc_data_i,
   input  wire logic [NUM_IN_MAX-1:0]                pulse_pin_i,
   input  wire logic [NUM_OUT_MAX-1:0][1:0]          switch_i,
   // Output drive and indicators.
   output logic [NUM_AO_MAX-1:0][AO_W-1:0]           ao_code_o,
   output logic [NUM_RELAY-1:0]                      relay_o,
   output logic [NUM_IN_MAX-1:0]                     in_led_o,
   output logic [NUM_OUT_MAX-1:0]                    out_led_o,
   output logic [NUM_IN_MAX-1:0]                     pulse_tick_o
);

   // ----------------------------------------------------------------------
   // Variant selections
   // ----------------------------------------------------------------------
   localparam logic        IS_4AO    = (VARIANT == VAR_FOUR_AO);
   localparam logic [3:0]  IN_COUNT  = IS_4AO ? 4'(NUM_IN_4AO) : 4'(NUM_IN_8AI);
   localparam int          OUT_COUNT = IS_4AO ? NUM_OUT_4AO : NUM_OUT_8AI;
   localparam int          AO_COUNT  = IS_4AO ? NUM_AO_4AO : NUM_AO_8AI;
   localparam logic [11:0] IN_FULL   = IS_4AO ? IN_FULL_4AO : IN_FULL_BASE;
   localparam logic [11:0] IN_LED_TH = IS_4AO ? IN_LED_4AO : IN_LED_BASE;

   // ----------------------------------------------------------------------
   // Decoding functions
   // ----------------------------------------------------------------------
   // Maps an address to the register group that holds it.
   function automatic reg_sel_type decode_sel(input logic [15:0] addr);
      logic [15:0] in_base;
      logic [15:0] in_end;
      logic [15:0] out_end;
      logic [15:0] range_end;
      begin
         in_base   = IS_4AO ? ADDR_IN_4AO : ADDR_IN_8AI;
         in_end    = in_base + {12'h000, IN_COUNT};
         out_end   = ADDR_OUT_BASE + 16'(OUT_COUNT);
         range_end = ADDR_RANGE_BASE + 16'(NUM_IN_4AO);
         if (addr == ADDR_TRIM) begin
            decode_sel = REG_TRIM;
         end else if (addr == ADDR_RATE) begin
            decode_sel = REG_RATE;
         end else if (addr >= in_base && addr < in_end) begin
            decode_sel = REG_IN;
         end else if (addr >= ADDR_OUT_BASE && addr < out_end) begin
            decode_sel = REG_OUT;
         end else if (IS_4AO && addr >= ADDR_RANGE_BASE && addr < range_end) begin
            decode_sel = REG_RANGE;
         end else begin
            decode_sel = REG_NONE;
         end
      end
   endfunction : decode_sel

   // Gives the channel index inside a register group.
   function automatic logic [3:0] decode_idx(input logic [15:0] addr, input reg_sel_type sel);
      logic [15:0] off;
      begin
         case (sel)
            REG_OUT:   off = addr - ADDR_OUT_BASE;
            REG_IN:    off = addr - (IS_4AO ? ADDR_IN_4AO : ADDR_IN_8AI);
            REG_RANGE: off = addr - ADDR_RANGE_BASE;
            default:   off = 16'h0000;
         endcase
         decode_idx = off[3:0];
      end
   endfunction : decode_idx

   // Analog drive in 10 mV steps from switch, level and trim.
   function automatic logic [AO_W-1:0] ao_drive(input logic [1:0] sw, input logic [15:0] level,
                                                input logic [7:0] trim_v);
      logic [10:0] lv;
      logic [17:0] prod;
      logic [12:0] tmp;
      logic [12:0] adj;
      begin
         lv   = (level > AO_LEVEL_FULL) ? AO_LEVEL_FULL[10:0] : level[10:0];
         prod = {7'h00, lv} * AO_SCALE_MUL;
         tmp  = {3'b000, prod[16:7]} + {5'b00000, trim_v};
         adj  = tmp - AO_OFFSET_ZERO;
         case (switch_type'(sw))
            SW_HAND: ao_drive = AO_FULL;
            SW_AUTO: begin
               if (tmp < AO_OFFSET_ZERO) begin
                  ao_drive = 10'h000;
               end else if (adj > {3'b000, AO_FULL}) begin
                  ao_drive = AO_FULL;
               end else begin
                  ao_drive = adj[AO_W-1:0];
               end
            end
            default: ao_drive = 10'h000;
         endcase
      end
   endfunction : ao_drive

   // Relay or sinking drive from switch and level.
   function automatic logic relay_drive(input logic [1:0] sw, input logic [15:0] level);
      begin
         case (switch_type'(sw))
            SW_HAND: relay_drive = 1'b1;
            SW_AUTO: relay_drive = level > OUT_ON_THRESH;
            default: relay_drive = 1'b0;
         endcase
      end
   endfunction : relay_drive

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [7:0]        trim;
   logic [7:0]        rate_reg;
   logic [15:0]       out_level [NUM_OUT_MAX];
   logic [11:0]       in_value [NUM_IN_MAX];
   logic [7:0]        range_code [NUM_IN_MAX];
   logic [1:0]        sw_meta [NUM_OUT_MAX];
   logic [1:0]        sw_sync [NUM_OUT_MAX];
   reg_sel_type       sel;
   logic [3:0]        idx;
   logic              write_legal;
   logic              wr_ok;
   logic [15:0]       rd_value;

   // Address decode of the current request.
   always_comb begin
      sel   = decode_sel(addr_i);
      idx   = decode_idx(addr_i, sel);
      wr_ok = req_i && wr_i && write_legal;
   end

   // Only mapped writable registers with in-range values accept a write.
   always_comb begin
      case (sel)
         REG_TRIM:  write_legal = wdata_i <= TRIM_MAX;
         REG_RATE:  write_legal = wdata_i <= RATE_MAX;
         REG_OUT:   write_legal = 1'b1;
         REG_RANGE: write_legal = wdata_i <= RANGE_MAX;
         default:   write_legal = 1'b0;
      endcase
   end

   // Read data multiplexer.
   always_comb begin
      case (sel)
         REG_TRIM:  rd_value = {8'h00, trim};
         REG_RATE:  rd_value = {8'h00, rate_reg};
         REG_OUT:   rd_value = out_level[idx];
         REG_IN:    rd_value = {4'h0, in_value[idx]};
         REG_RANGE: rd_value = {8'h00, range_code[idx]};
         default:   rd_value = 16'h0000;
      endcase
   end

   // Answers every request one cycle later; refused accesses flag an exception.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_o   <= 1'b0;
         exc_o   <= 1'b0;
         rdata_o <= 16'h0000;
      end else begin
         ack_o <= req_i;
         exc_o <= req_i && (wr_i ? !write_legal : (sel == REG_NONE));
         if (req_i) begin
            rdata_o <= wr_i ? 16'h0000 : rd_value;
         end
      end
   end

   // Trim starts neutral, is reloaded from the store and saved on each write.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trim      <= TRIM_RESET;
         nv_wr_o   <= 1'b0;
         nv_data_o <= TRIM_RESET;
      end else begin
         nv_wr_o <= wr_ok && sel == REG_TRIM;
         if (wr_ok && sel == REG_TRIM) begin
            trim      <= wdata_i[7:0];
            nv_data_o <= wdata_i[7:0];
         end else if (nv_valid_i) begin
            trim <= nv_trim_i;
         end
      end
   end

   // The line rate only switches once the pending response is on the wire.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_reg   <= RATE_RESET;
         baud_sel_o <= RATE_RESET[0];
      end else begin
         if (wr_ok && sel == REG_RATE) begin
            rate_reg <= wdata_i[7:0];
         end
         if (resp_done_i) begin
            baud_sel_o <= rate_reg[0];
         end
      end
   end

   // Output levels are volatile and come up cleared.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int k = 0; k < NUM_OUT_MAX; k++) begin
            out_level[k] <= 16'h0000;
         end
      end else if (wr_ok && sel == REG_OUT) begin
         out_level[idx] <= wdata_i;
      end
   end

   // Range codes per input.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int k = 0; k < NUM_IN_MAX; k++) begin
            range_code[k] <= RANGE_RESET;
         end
      end else if (wr_ok && sel == REG_RANGE) begin
         range_code[idx] <= wdata_i[7:0];
      end
   end

   // Converter results are clamped to the variant's full scale.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int k = 0; k < NUM_IN_MAX; k++) begin
            in_value[k] <= 12'h000;
         end
      end else if (adc_valid_i && adc_chan_i < IN_COUNT) begin
         in_value[adc_chan_i] <= (adc_data_i > IN_FULL) ? IN_FULL : adc_data_i;
      end
   end

   // ----------------------------------------------------------------------
   // Per-channel logic
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < NUM_IN_MAX; g++) begin : g_in
      // Input indicator follows the variant threshold.
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            in_led_o[g] <= 1'b0;
         end else begin
            in_led_o[g] <= (4'(g) < IN_COUNT) && in_value[g] > IN_LED_TH;
         end
      end

      // Pulse counting is enabled by the pulse range code.
      pulse_filter u_pulse (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .pin_i     (pulse_pin_i[g]),
         .enable_i  (range_code[g] == RANGE_PULSE),
         .rise_o    (pulse_tick_o[g])
      );
   end

   for (genvar g = 0; g < NUM_OUT_MAX; g++) begin : g_out
      // Switch pins pass two flip-flops.
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            sw_meta[g] <= 2'b00;
            sw_sync[g] <= 2'b00;
         end else begin
            sw_meta[g] <= switch_i[g];
            sw_sync[g] <= sw_meta[g];
         end
      end

      // Output indicator shows the register above half scale.
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            out_led_o[g] <= 1'b0;
         end else begin
            out_led_o[g] <= (g < OUT_COUNT) && out_level[g] > OUT_ON_THRESH;
         end
      end
   end

   for (genvar g = 0; g < NUM_AO_MAX; g++) begin : g_ao
      // Analog drive for channels the variant has.
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            ao_code_o[g] <= 10'h000;
         end else begin
            ao_code_o[g] <= (g < AO_COUNT) ? ao_drive(sw_sync[g], out_level[g], trim) : 10'h000;
         end
      end
   end

   for (genvar g = 0; g < NUM_RELAY; g++) begin : g_relay
      // Relays follow the outputs after the analog channels.
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            relay_o[g] <= 1'b0;
         end else begin
            relay_o[g] <= IS_4AO && relay_drive(sw_sync[g + NUM_AO_4AO], out_level[g + NUM_AO_4AO]);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   logic in0_hot;
   logic out0_hot;
   logic relay0_want;
   assign in0_hot     = in_value[0] > IN_LED_TH;
   assign out0_hot    = out_level[0] > OUT_ON_THRESH;
   assign relay0_want = out_level[NUM_AO_4AO] > OUT_ON_THRESH;

   a_ack_timing: assert property (req_i |=> ack_o ##1 !ack_o || $past(req_i))
      else $error("Request not answered in the next cycle.");
   a_unmapped_exc: assert property (req_i && sel == REG_NONE |=> ack_o && exc_o)
      else $error("Unmapped access gave no exception.");
   a_input_ro: assert property (req_i && wr_i && sel == REG_IN |=> exc_o && $stable(in_value[0]) || $past(adc_valid_i))
      else $error("Write to input value register accepted.");
   a_range_limit: assert property (req_i && wr_i && sel == REG_RANGE && wdata_i > RANGE_MAX |=> exc_o)
      else $error("Out of range code accepted.");
   a_rate_switch: assert property ($changed(baud_sel_o) |-> $past(resp_done_i))
      else $error("Line rate changed before response end.");
   a_trim_reload: assert property (nv_valid_i && !(wr_ok && sel == REG_TRIM) |=> trim == $past(nv_trim_i))
      else $error("Stored trim not reloaded.");
   a_in_led_level: assert property (in_led_o[0] == $past(in0_hot))
      else $error("Input indicator disagrees with value.");
   a_out_led_level: assert property (out_led_o[0] == $past(out0_hot))
      else $error("Output indicator disagrees with register.");
   a_ao_off_zero: assert property (sw_sync[0] == SW_OFF |=> ao_code_o[0] == 10'h000)
      else $error("Analog output not zero in off position.");
   a_ao_hand_full: assert property (sw_sync[0] == SW_HAND |=> ao_code_o[0] == AO_FULL)
      else $error("Analog output not full in hand position.");
   a_ao_auto_full: assert property (sw_sync[0] == SW_AUTO && out_level[0] == AO_LEVEL_FULL && trim == TRIM_RESET
      |=> ao_code_o[0] == AO_FULL)
      else $error("Full scale register did not give full drive.");
   a_relay_auto: assert property (IS_4AO && sw_sync[NUM_AO_4AO] == SW_AUTO |=> relay_o[0] == $past(relay0_want))
      else $error("Relay does not follow its register in auto.");

   c_out_write: cover property (wr_ok && sel == REG_OUT);
   c_rate_apply: cover property ($changed(baud_sel_o));
   c_pulse_tick: cover property (pulse_tick_o[0]);
   c_exception: cover property (exc_o);

endmodule : io_register_bank

// File: tb/bus_master_model.sv
`timescale 1ns/1ns
module bus_master_model (
   // Commands from the bench and answer strobe.
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] data_i,
   input  wire logic        ack_i,
   // Decoded request side of the block.
   output logic             req_o,
   output logic             wr_o,
   output logic [15:0]      addr_o,
   output logic [15:0]      wdata_o,
   output logic             resp_done_o
);
   logic sent;
   // Qualifiers are inverted outside a request so stale values never pass.
   assign req_o   = go_i;
   assign wr_o    = go_i ? wr_i : ~wr_i;
   assign addr_o  = go_i ? addr_i : ~addr_i;
   assign wdata_o = go_i ? data_i : ~data_i;
   // The response leaves the line two cycles after the answer.
   always_ff @(posedge clk_i) begin
      sent        <= ack_i;
      resp_done_o <= sent;
   end
endmodule : bus_master_model

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import io_bank_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, go = 0, wr = 0, adc_valid_i = 0, nv_valid_i = 0;
   logic req_i, wr_i, ack_o, exc_o, resp_done_i, baud_sel_o, nv_wr_o;
   logic [15:0] addr = 16'h0, data = 16'h0, addr_i, wdata_i, rdata_o;
   logic [7:0]  nv_trim_i = 8'h90, relay_o, nv_data_o;
   logic [3:0]  adc_chan_i = 4'h9;
   logic [11:0] adc_data_i = 12'h800, out_led_o;
   logic [9:0]  in_led_o, pin = 10'h000, tick;
   logic [NUM_OUT_MAX-1:0][1:0]      switch_i = {12{2'h1}};
   logic [NUM_AO_MAX-1:0][AO_W-1:0] ao_code_o;
   int error_cnt = 0, comparisons = 0;
   io_register_bank uut (.clk_i, .sys_rst_i, .req_i, .wr_i, .addr_i, .wdata_i, .ack_o, .exc_o,
      .rdata_o, .resp_done_i, .baud_sel_o, .nv_valid_i, .nv_trim_i, .nv_wr_o, .nv_data_o,
      .adc_valid_i, .adc_chan_i, .adc_data_i, .pulse_pin_i(pin), .switch_i, .ao_code_o,
      .relay_o, .in_led_o, .out_led_o, .pulse_tick_o(tick));
   bus_master_model master (.clk_i, .go_i(go), .wr_i(wr), .addr_i(addr), .data_i(data),
      .ack_i(ack_o), .req_o(req_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i),
      .resp_done_o(resp_done_i));
   // Free-running clock.
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #10;
   endtask : cyc
   // One register request; the answer is checked one edge later.
   task automatic acc(input logic w, input logic [15:0] a, d, e, input logic x);
      @(posedge clk_i) #10 {go, wr, addr, data} = {1'b1, w, a, d};
      @(posedge clk_i) #10 go = 0;
      chk("ack", 16'h1, {15'h0, ack_o});
      chk("exc", {15'h0, x}, {15'h0, exc_o});
      if (!w) chk("rdata", e, rdata_o);
   endtask : acc
   task automatic stop_test;
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   // Watchdog against a hung handshake.
   initial begin
      #300_000;
      error_cnt++;
      stop_test;
   end
   // Main sequence of register traffic.
   initial begin
      cyc(10);
      sys_rst_i = 0;
      chk("baud", 16'h1, {15'h0, baud_sel_o});
      acc(0, 16'h000D, 16'h0, 16'h0080, 0);
      acc(0, 16'h000F, 16'h0, 16'h0001, 0);
      acc(0, 16'h0064, 16'h0, 16'h0000, 0);
      acc(1, 16'h0064, 16'h03E8, 16'h0, 0);
      acc(1, 16'h0068, 16'h0201, 16'h0, 0);
      acc(1, 16'h0069, 16'h0200, 16'h0, 0);
      cyc(2);
      chk("ao0", 16'h03D0, {6'h0, ao_code_o[0]});
      chk("oled", 16'h1, {15'h0, out_led_o[0]});
      chk("relay", 16'h1, {14'h0, relay_o[1:0]});
      acc(0, 16'h0064, 16'h0, 16'h03E8, 0);
      acc(1, 16'h00BE, 16'h1, 16'h0, 1);
      acc(1, 16'h0070, 16'h1, 16'h0, 1);
      acc(0, 16'h00BE, 16'h0, 16'h0000, 0);
      switch_i[0] = 2'h3;
      cyc(4);
      chk("hand", 16'h03E8, {6'h0, ao_code_o[0]});
      switch_i[0] = 2'h0;
      cyc(4);
      chk("off", 16'h0, {6'h0, ao_code_o[0]});
      switch_i[0] = 2'h1;
      acc(1, 16'h0064, 16'h0200, 16'h0, 0);
      acc(1, 16'h000D, 16'h0000, 16'h0, 0);
      chk("nvwr", 16'h1, {15'h0, nv_wr_o});
      chk("nvdata", 16'h0, {8'h0, nv_data_o});
      cyc(4);
      chk("trim", 16'h0174, {6'h0, ao_code_o[0]});
      chk("oled", 16'h0, {15'h0, out_led_o[0]});
      adc_valid_i = 1;
      cyc(1);
      adc_valid_i = 0;
      cyc(2);
      chk("iled", 16'h1, {15'h0, in_led_o[9]});
      acc(0, 16'h00C7, 16'h0, 16'h0800, 0);
      acc(1, 16'h00C8, 16'h0006, 16'h0, 0);
      acc(1, 16'h00D1, 16'h000E, 16'h0, 1);
      acc(0, 16'h00C8, 16'h0, 16'h0006, 0);
      pin = 10'h3FF;
      cyc(PULSE_FILTER_CYC + 1);
      chk("tick", 16'h0, {6'h0, tick});
      cyc(1);
      chk("tick", 16'h1, {6'h0, tick});
      cyc(1);
      chk("tick", 16'h0, {6'h0, tick});
      nv_valid_i = 1;
      cyc(1);
      nv_valid_i = 0;
      acc(0, 16'h000D, 16'h0, 16'h0090, 0);
      cyc(2);
      acc(1, 16'h000F, 16'h0000, 16'h0, 0);
      chk("baud", 16'h1, {15'h0, baud_sel_o});
      cyc(2);
      chk("baud", 16'h1, {15'h0, baud_sel_o});
      cyc(1);
      chk("baud", 16'h0, {15'h0, baud_sel_o});
      stop_test;
   end
endmodule : testbench
